//--- src/srpw_pkg.sv
// Purpose: shared constants and types for the serial register port with watchdog
// Assumes: system clock 40 MHz, watchdog timebase from a 32.768 kHz derived tick
// Notes:   addresses are the 6-bit register addresses of the command word
package srpw_pkg;

  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned CMD_BITS      = 8;
  localparam int unsigned ADDR_BITS     = 6;
  localparam int unsigned DATA_MAX      = 40;
  localparam int unsigned LEN_W         = 6;
  localparam int unsigned CMD_START_POS = 7;
  localparam int unsigned CMD_RW_POS    = 6;

  // register addresses
  localparam logic [5:0] ADR_ADC      = 6'h00;
  localparam logic [5:0] ADR_MUX      = 6'h01;
  localparam logic [5:0] ADR_DATA     = 6'h02;
  localparam logic [5:0] ADR_OFFSET   = 6'h03;
  localparam logic [5:0] ADR_GAIN     = 6'h04;
  localparam logic [5:0] ADR_CLK_CTRL = 6'h0B;
  localparam logic [5:0] ADR_RTC      = 6'h0C;
  localparam logic [5:0] ADR_WATCHDOG = 6'h0F;

  // data phase lengths
  localparam logic [5:0] LEN_8  = 6'h08;
  localparam logic [5:0] LEN_16 = 6'h10;
  localparam logic [5:0] LEN_24 = 6'h18;
  localparam logic [5:0] LEN_40 = 6'h28;

  // field positions
  localparam int unsigned WDE_POS  = 0;  // watchdog_enable_bit in clock control
  localparam int unsigned CONVERSION_START_BIT_POS = 14; // conversion_start_bit in adc control

  // reset values
  localparam logic [15:0] CLK_CTRL_RST = 16'h0000;
  localparam logic [15:0] ADC_RST      = 16'h0000;

  // watchdog timing in milliseconds, counted on the slow tick
  localparam int unsigned WD_SERVICE_MS = 500;
  localparam int unsigned WD_RESET_MS   = 250;
  localparam int unsigned WD_TICK_HZ    = 4;   // 250 ms slow tick
  localparam logic [1:0]  WD_SERVICE_TK = 2'(WD_SERVICE_MS * WD_TICK_HZ / 1000);
  localparam logic [1:0]  WD_RESET_TK   = 2'(WD_RESET_MS * WD_TICK_HZ / 1000);

  // committed write passed from link domain to system domain
  typedef struct packed {
    logic [5:0]  addr;
    logic [39:0] data;
  } srpw_wr_s;

  typedef enum logic [1:0] {
    SRPW_IDLE = 2'b00,
    SRPW_CMD  = 2'b01,
    SRPW_DATA = 2'b11,
    SRPW_DONE = 2'b10
  } srpw_state_e;

endpackage : srpw_pkg

//--- src/srpw_watchdog.sv
// Purpose: watchdog timer on a slow tick with reset pulse output
// Assumes: tick_i is a one-cycle pulse in the clk_i domain
// Notes:   timeout lands between two and three ticks after service
`timescale 1ns/1ps
`default_nettype none
module srpw_watchdog (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic enable_i,
  input  wire logic service_i,
  input  wire logic tick_i,
  output logic      wd_reset_o
);
  import srpw_pkg::*;

  logic [1:0] svc_cnt;
  logic [1:0] rst_cnt;
  wire        expire = tick_i && (svc_cnt == WD_SERVICE_TK);

  // service window and reset pulse, both counted on the slow tick
  always_ff @(posedge clk_i) begin
    if (reset_i || !enable_i) begin
      svc_cnt <= 2'h0;
      rst_cnt <= 2'h0;
    end else begin
      if (service_i || expire) svc_cnt <= 2'h0;
      else if (tick_i) svc_cnt <= svc_cnt + 2'h1;
      if (expire) rst_cnt <= WD_RESET_TK;
      else if (tick_i && rst_cnt != 2'h0) rst_cnt <= rst_cnt - 2'h1;
    end
  end

  assign wd_reset_o = (rst_cnt != 2'h0);

endmodule : srpw_watchdog
`default_nettype wire

//--- src/srpw_top.sv
// Purpose: four-wire serial register port with watchdog service
// Assumes: sclk_i is the link clock, gated by the master outside frames
// Notes:   writes cross to clk_i by a toggle handshake; reads sample system values directly
//
// Overview of operation
// - bits are taken or shifted only while chip select is low
// - serial data output is released whenever chip select is high
// - serial input sampled on every rising serial clock edge
// - serial output changes on every falling serial clock edge
// - works with clock polarity/phase 0/0 and 1/1 only
// - writes commit only on the final rising serial clock edge
// - chip select rising early discards the pending write
// - command word: start bit, read/write bit, six address bits
// - command valid only once a start bit of 1 arrives
// - zeros before the start bit are ignored as padding
// - writing watchdog enable bit 1 starts the watchdog
// - missing service in 500 ms gives a 250 ms reset pulse
// - timeout lands between 500 ms and 750 ms after service
// - writing watchdog enable bit 0 stops the watchdog
// - time register moves all 40 bits in one transfer
// - conversion starts right after the sixteenth control data bit
`timescale 1ns/1ps
`default_nettype none
module srpw_top (
  input  wire logic                   clk_i,
  input  wire logic                   reset_i,
  input  wire logic                   sclk_i,
  input  wire logic                   cs_n_i,
  input  wire logic                   din_i,
  output logic                        dout_o,
  output logic                        dout_oe_n_o,
  input  wire logic                   wd_tick_i,
  input  wire logic [15:0]            adc_data_i,
  output logic [15:0]                 adc_ctrl_o,
  output logic [15:0]                 clk_ctrl_o,
  output logic [srpw_pkg::DATA_MAX-1:0] rtc_load_o,
  output logic                        rtc_load_valid_o,
  input  wire logic [srpw_pkg::DATA_MAX-1:0] rtc_time_i,
  output logic                        conv_start_o,
  output logic                        wd_reset_o
);
  import srpw_pkg::*;

  // ---------------- link domain ----------------
  srpw_state_e       state;
  logic [7:0]        cmd_sr;
  logic [2:0]        cmd_cnt;
  logic [5:0]        data_cnt;
  logic [5:0]        data_len;
  logic [5:0]        addr;
  logic              is_read;
  logic [39:0]       rx_sr;
  logic [39:0]       tx_sr;
  logic              tx_bit;
  logic              drive;
  srpw_wr_s          wr_hold;
  logic              wr_tog;
  logic              conversion_start_bit_tog;

  // width per address, everything unlisted moves a byte
  function automatic logic [5:0] reg_len(input logic [5:0] a);
    logic [5:0] l;
    l = LEN_8;
    if (a == ADR_RTC) l = LEN_40;
    else if (a == ADR_OFFSET || a == ADR_GAIN) l = LEN_24;
    else if (a == ADR_ADC || a == ADR_MUX || a == ADR_DATA || a == ADR_CLK_CTRL) l = LEN_16;
    return l;
  endfunction : reg_len

  // readback, aligned to the top of the shifter; sampled values are quasi-static
  logic [39:0] rd_word;
  wire  [5:0]  nxt_addr = {cmd_sr[4:0], din_i};
  wire  [15:0] rd16 = (nxt_addr == ADR_ADC)      ? adc_ctrl_o :
                      (nxt_addr == ADR_CLK_CTRL) ? clk_ctrl_o :
                      (nxt_addr == ADR_DATA)     ? adc_data_i : 16'h0000;
  assign rd_word = (nxt_addr == ADR_RTC) ? rtc_time_i : {rd16, 24'h000000};

  wire cmd_last  = (state == SRPW_CMD) && (cmd_cnt == 3'(CMD_BITS - 2));
  wire data_last = (state == SRPW_DATA) && (data_cnt == data_len - 6'h01);

  // command and data shifting on the rising edge; chip select acts as frame reset
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      state    <= SRPW_IDLE;
      cmd_cnt  <= 3'h0;
      data_cnt <= 6'h00;
      cmd_sr   <= 8'h00;
      data_len <= LEN_8;
      addr     <= 6'h00;
      is_read  <= 1'b0;
      rx_sr    <= 40'h0;
      tx_sr    <= 40'h0;
    end else begin
      case (state)
        SRPW_IDLE: begin
          if (din_i) begin
            state   <= SRPW_CMD;
            cmd_cnt <= 3'h0;
          end
        end
        SRPW_CMD: begin
          cmd_sr  <= {cmd_sr[6:0], din_i};
          cmd_cnt <= cmd_cnt + 3'h1;
          if (cmd_last) begin
            state    <= SRPW_DATA;
            addr     <= nxt_addr;
            is_read  <= cmd_sr[CMD_RW_POS - 1]; // read/write flag sits above the address bits
            data_len <= reg_len(nxt_addr);
            data_cnt <= 6'h00;
            tx_sr    <= rd_word;
          end
        end
        SRPW_DATA: begin
          rx_sr    <= {rx_sr[38:0], din_i};
          tx_sr    <= {tx_sr[38:0], 1'b0};
          data_cnt <= data_cnt + 6'h01;
          if (data_last) state <= SRPW_DONE;
        end
        default: state <= SRPW_DONE; // extra clocks ignored
      endcase
    end
  end

  // commit on the final rising edge; the master holds cs low through it
  always_ff @(posedge sclk_i or posedge reset_i) begin
    if (reset_i) begin
      wr_tog   <= 1'b0;
      conversion_start_bit_tog <= 1'b0;
      wr_hold  <= '0;
    end else if (!cs_n_i && data_last && !is_read) begin
      wr_hold  <= '{addr: addr, data: {rx_sr[38:0], din_i}};
      wr_tog   <= ~wr_tog;
      if (addr == ADR_ADC && rx_sr[CONVERSION_START_BIT_POS - 1]) conversion_start_bit_tog <= ~conversion_start_bit_tog;
    end
  end

  // output on the falling edge; first bit follows the last command bit
  always_ff @(negedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      tx_bit <= 1'b0;
      drive  <= 1'b0;
    end else begin
      drive  <= (state == SRPW_DATA) && is_read;
      tx_bit <= tx_sr[DATA_MAX-1];
    end
  end

  assign dout_o      = tx_bit;
  assign dout_oe_n_o = !(drive && !cs_n_i);

  // ---------------- system domain ----------------
  logic [2:0] wr_sync;
  logic [2:0] st_sync;
  logic [1:0] tk_sync;
  logic       tk_d;
  wire        wr_ev = wr_sync[2] ^ wr_sync[1];
  wire        st_ev = st_sync[2] ^ st_sync[1];

  // toggle crossings; hold register is stable when the toggle lands
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wr_sync <= 3'h0;
      st_sync <= 3'h0;
      tk_sync <= 2'h0;
      tk_d    <= 1'b0;
    end else begin
      wr_sync <= {wr_sync[1:0], wr_tog};
      st_sync <= {st_sync[1:0], conversion_start_bit_tog};
      tk_sync <= {tk_sync[0], wd_tick_i};
      tk_d    <= tk_sync[1];
    end
  end

  wire svc = wr_ev && (wr_hold.addr == ADR_WATCHDOG);

  // register updates from committed writes
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      adc_ctrl_o       <= ADC_RST;
      clk_ctrl_o       <= CLK_CTRL_RST;
      rtc_load_o       <= '0;
      rtc_load_valid_o <= 1'b0;
      conv_start_o     <= 1'b0;
    end else begin
      rtc_load_valid_o <= 1'b0;
      conv_start_o     <= st_ev;
      if (wr_ev && wr_hold.addr == ADR_ADC) adc_ctrl_o <= wr_hold.data[15:0];
      if (wr_ev && wr_hold.addr == ADR_CLK_CTRL) clk_ctrl_o <= wr_hold.data[15:0];
      if (wr_ev && wr_hold.addr == ADR_RTC) begin
        rtc_load_o       <= wr_hold.data;
        rtc_load_valid_o <= 1'b1;
      end
    end
  end

  srpw_watchdog u_wd (
    .clk_i      (clk_i),
    .reset_i    (reset_i),
    .enable_i   (clk_ctrl_o[WDE_POS]),
    .service_i  (svc),
    .tick_i     (tk_sync[1] && !tk_d),
    .wd_reset_o (wd_reset_o)
  );

endmodule : srpw_top
`default_nettype wire

//--- bench/srpw_checker.sv
// Purpose: port checks for the serial register port
// Assumes: all sampled on clk_i; sclk is far slower
// Notes:   watchdog edges must line up with the slow tick
`timescale 1ns/1ps
`default_nettype none
module srpw_checker (
  input wire logic        clk_i,
  input wire logic        reset_i,
  input wire logic        sclk_i,
  input wire logic        cs_n_i,
  input wire logic        dout_o,
  input wire logic        dout_oe_n_o,
  input wire logic        wd_tick_i,
  input wire logic [15:0] adc_ctrl_o,
  input wire logic [15:0] clk_ctrl_o,
  input wire logic        rtc_load_valid_o,
  input wire logic        conv_start_o,
  input wire logic        wd_reset_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // output released when deselected and quiet while sclk is high
  a_oe_idle_off: assert property (cs_n_i && $past(cs_n_i) |-> dout_oe_n_o)
    else $error("dout driven while deselected");
  a_dout_hold_high: assert property (sclk_i && $past(sclk_i) && !cs_n_i && !$past(cs_n_i)
    |-> $stable(dout_o)) else $error("dout moved while sclk high");
  // strobes are single cycle, start follows its control bit
  a_conv_one_cycle: assert property (conv_start_o |=> !conv_start_o)
    else $error("start pulse too long");
  a_rtc_one_cycle: assert property (rtc_load_valid_o |=> !rtc_load_valid_o)
    else $error("load pulse too long");
  a_conv_needs_bit: assert property (conv_start_o |=> adc_ctrl_o[14])
    else $error("start without its control bit");
  // watchdog pulses only when enabled and on tick edges
  a_wd_needs_en: assert property ($rose(wd_reset_o) |-> $past(clk_ctrl_o[0]))
    else $error("watchdog reset while disabled");
  a_wd_rise_tick: assert property ($rose(wd_reset_o) |-> wd_tick_i)
    else $error("watchdog reset off the tick");
  a_wd_fall_tick: assert property ($fell(wd_reset_o) && clk_ctrl_o[0] |-> wd_tick_i)
    else $error("watchdog pulse ended off the tick");
endmodule : srpw_checker
`default_nettype wire

//--- bench/srpw_master.sv
// Purpose: spi master model for the serial port
// Assumes: 64 ns bit time, modes 0/0 and 1/1
// Notes:   a released dout reads as the inverse of its last bit
`timescale 1ns/1ps
`default_nettype none
module srpw_master (
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      din_o,
  input  wire logic dout_i,
  input  wire logic dout_oe_n_i
);
  logic last = 1'b0;
  wire  miso = dout_oe_n_i ? ~last : dout_i;
  // keep last driven bit so a floating line never looks valid
  always @(dout_i) if (!dout_oe_n_i) last = dout_i;
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    din_o = 1'b0;
  end
  // one framed transfer msb first; clock parks at the mode level
  task automatic xfer(input logic m, input logic [63:0] v, input int n,
                      output logic [63:0] rd);
    rd = '0;
    sclk_o = m;
    #20 cs_n_o = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      sclk_o = 1'b0;
      din_o = v[i];
      #32 sclk_o = 1'b1;
      rd = {rd[62:0], miso};
      #32;
    end
    sclk_o = m;
    #20 cs_n_o = 1'b1;
    #40;
  endtask : xfer
endmodule : srpw_master
`default_nettype wire

//--- bench/test_serial_register_port_watchdog.sv
// Purpose: self-checking bench for the serial register port
// Assumes: 10 us watchdog tick shortens the long counts
// Notes:   expectations follow the command format and lengths
`timescale 1ns/1ps
`default_nettype none
module test_serial_register_port_watchdog;
  import srpw_pkg::*;
  logic        clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        tick = 1'b0;
  logic        sclk, cs_n, din, dout, oe_n, rtc_v, conv, wd_rst;
  logic [15:0] adc_data = 16'h0000;
  logic [15:0] adc_ctrl, clk_ctrl, d;
  logic [39:0] rtc_time = 40'h0000000000;
  logic [39:0] rtc_load, q;
  logic [31:0] seed = 32'h4183;
  int          n_fail = 0, num_checks = 0, n_conv = 0, n_rtc = 0, n_wd = 0, w, c;
  srpw_top dut (.clk_i(clk_i), .reset_i(reset_i), .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din),
    .dout_o(dout), .dout_oe_n_o(oe_n), .wd_tick_i(tick), .adc_data_i(adc_data),
    .adc_ctrl_o(adc_ctrl), .clk_ctrl_o(clk_ctrl), .rtc_load_o(rtc_load),
    .rtc_load_valid_o(rtc_v), .rtc_time_i(rtc_time), .conv_start_o(conv), .wd_reset_o(wd_rst));
  srpw_master mst (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .dout_i(dout), .dout_oe_n_i(oe_n));
  // system clock and slow tick, both off the sampling edges
  initial forever #12.5 clk_i = ~clk_i;
  initial forever #5000 tick = ~tick;
  // pulse and reset-cycle counters
  always @(posedge clk_i) begin
    n_conv += conv;
    n_rtc += rtc_v;
    n_wd += wd_rst;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic int len(logic [5:0] a);
    if (a <= ADR_DATA || a == ADR_CLK_CTRL) return 16;
    if (a == ADR_OFFSET || a == ADR_GAIN) return 24;
    return (a == ADR_RTC) ? 40 : 8;
  endfunction : len
  task automatic chk(string s, logic [39:0] e, logic [39:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  // write with zero padding; cut drops trailing bits to abort
  task automatic wr(logic m, logic [5:0] a, logic [39:0] v, int pad, int cut);
    logic [63:0] r;
    mst.xfer(m, ({56'h0, 2'b10, a} << len(a) | 64'(v)) >> cut, 8 + len(a) + pad - cut, r);
    repeat (8) @(posedge clk_i);
    #2;
  endtask : wr
  task automatic rdr(logic m, logic [5:0] a, output logic [39:0] o);
    logic [63:0] r;
    mst.xfer(m, {56'h0, 2'b11, a} << len(a), 8 + len(a), r);
    o = 40'(r & ((64'h1 << len(a)) - 64'h1));
  endtask : rdr
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  initial begin
    repeat (5) @(posedge clk_i);
    #2 reset_i = 1'b0;
    #50;
    chk("oe_idle", 1, 40'(oe_n));
    chk("ctrl_rst", 40'({CLK_CTRL_RST, ADC_RST}), 40'({clk_ctrl, adc_ctrl}));
    for (int i = 0; i < 8; i++) begin
      d = 16'(rnd());
      if (i < 2) d[14] = i[0];
      c = n_conv;
      wr(i[0], ADR_ADC, 40'(d), i, 0);
      chk("adc_ctrl", 40'(d), 40'(adc_ctrl));
      chk("conv_cnt", 40'(d[14]), 40'(n_conv - c));
      adc_data = 16'(rnd());
      rdr(i[0], ADR_DATA, q);
      chk("adc_rd", 40'(adc_data), q);
    end
    wr(1'b0, ADR_CLK_CTRL, 40'hFFFF, 0, 3);
    chk("abort", 40'h0, 40'(clk_ctrl));
    q = {rnd(), 8'(rnd())};
    c = n_rtc;
    wr(1'b1, ADR_RTC, q, 0, 0);
    chk("rtc_load", q, rtc_load);
    chk("rtc_cnt", 40'h1, 40'(n_rtc - c));
    rtc_time = {rnd(), 8'(rnd())};
    rdr(1'b0, ADR_RTC, q);
    chk("rtc_rd", rtc_time, q);
    rdr(1'b1, 6'h3E, q);
    chk("unmapped", 40'h0, q);
    wr(1'b0, ADR_CLK_CTRL, 40'h0001, 0, 0);
    chk("wd_en", 40'h1, 40'(clk_ctrl));
    for (int i = 0; i < 6; i++) begin
      #7500;
      wr(i[0], ADR_WATCHDOG, 40'h00, 0, 0);
    end
    #17500;
    chk("wd_early", 40'h0, 40'(n_wd));
    for (w = 0; w < 600 && wd_rst !== 1'b1; w++) #25;
    chk("wd_fire", 40'h1, 40'(w < 600));
    if (w == 600) stop_test();
    for (w = 0; w < 600 && wd_rst === 1'b1; w++) #25;
    chk("wd_len", 40'h1, 40'(w > 394 && w < 406));
    wr(1'b1, ADR_CLK_CTRL, 40'h0000, 0, 0);
    c = n_wd;
    #40000;
    chk("wd_off", 40'(c), 40'(n_wd));
    stop_test();
  end
endmodule : test_serial_register_port_watchdog
bind srpw_top srpw_checker u_chk (.clk_i(clk_i), .reset_i(reset_i), .sclk_i(sclk_i),
  .cs_n_i(cs_n_i), .dout_o(dout_o), .dout_oe_n_o(dout_oe_n_o), .wd_tick_i(wd_tick_i),
  .adc_ctrl_o(adc_ctrl_o), .clk_ctrl_o(clk_ctrl_o), .rtc_load_valid_o(rtc_load_valid_o),
  .conv_start_o(conv_start_o), .wd_reset_o(wd_reset_o));
`default_nettype wire
